// ### design/phm_phy.sv
// Purpose: PHY end of the MII data and management link
// Assumes: line side logic on clk; MAC pins cross two flops
// Notes: both MII clocks come from one divider
// Operation
// - MAC changes TXD on TX_CLK, bit0 LSB
// - MAC raises TX_EN only with valid nibble
// - PHY makes TX_CLK, 2.5 or 25 MHz
// - PHY updates RXD on RX_CLK, bit0 LSB
// - RX_DV high exactly while RXD valid
// - RX_ER flags receive error, on RX_CLK
// - MAC TX_ER synchronous to TX_CLK
// - PHY makes RX_CLK, 25 or 2.5 MHz
// - COL high for whole collision
// - COL asynchronous, off in full duplex
// - Half duplex: CRS on transmit or receive
// - Full duplex: CRS on receive only
// - CRS rises freely, falls on RX_CLK
// - Disable pin high ignores management frames
// - Disable low: pins only seed defaults
// - After reset only writes change bits; with disable high the pins keep setting speed and duplex
// - Manager keeps MDC at most 8 MHz
// - Enabled interrupt pulls line low
// - Reading register 19 releases interrupt
`timescale 1ns/1ns
`default_nettype none
module phm_phy
   import phm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // MII and management pins
   phm_if.phy mii,
   // Straps and configuration pins
   input wire logic mgmt_disable_pin,
   input wire logic [4:0] phy_addr_pin,
   input wire logic cfg_speed100_pin,
   input wire logic cfg_full_duplex_pin,
   // Line side transmit
   output logic [3:0] line_tx_data,
   output logic line_tx_en,
   output logic line_tx_er,
   // Line side receive
   input wire logic [3:0] line_rx_data,
   input wire logic line_rx_dv,
   input wire logic line_rx_er,
   output logic line_rx_take,
   // Line status
   input wire logic line_carrier,
   input wire logic line_link,
   output logic speed100,
   output logic full_duplex
);
   logic [15:0] pin_s;
   logic mdc_s;
   logic mdio_s;
   logic [3:0] txd_s;
   logic tx_en_s;
   logic tx_er_s;
   logic dis_s;
   logic [4:0] addr_s;
   logic spd_s;
   logic dup_s;
   logic mdc_prev_q;
   logic mdc_rise;
   phm_mstate_e state_q;
   logic [5:0] ones_q;
   logic [5:0] bitcnt_q;
   logic [15:0] sh_q;
   logic rd_q;
   logic wr_q;
   logic [4:0] reg_q;
   logic [15:0] rdata_q;
   logic mdio_o_q;
   logic mdio_oe_q;
   logic [13:0] hdr;
   logic hit;
   logic hdr_end;
   logic rd_clear;
   logic wr_commit;
   logic [15:0] wr_word;
   logic ctrl_wr;
   logic soft_rst;
   logic [15:0] rd_word;
   logic [15:0] ctrl_q;
   logic [1:0] init_cnt_q;
   logic init_done;
   logic [15:0] irq_en_q;
   logic [15:0] irq_st_q;
   logic link_prev_q;
   logic [4:0] div_q;
   logic [4:0] half;
   logic mii_clk_q;
   logic tick;
   logic rise_evt;
   logic fall_evt;
   logic [3:0] rxd_q;
   logic rx_dv_q;
   logic rx_er_q;
   logic crs_raw;
   logic crs_hold_q;

   phm_sync #(.W(16)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d({mii.mdc, mii.mdio, mii.txd, mii.tx_en, mii.tx_er, mgmt_disable_pin,
          phy_addr_pin, cfg_speed100_pin, cfg_full_duplex_pin}),
      .q(pin_s)
   );
   assign {mdc_s, mdio_s, txd_s, tx_en_s, tx_er_s, dis_s, addr_s, spd_s, dup_s} = pin_s;

   // Management clock edges
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mdc_prev_q <= 1'h0;
      end else begin
         mdc_prev_q <= mdc_s;
      end
   end
   assign mdc_rise = mdc_s & ~mdc_prev_q;

   // Header decode
   assign hdr = {sh_q[12:0], mdio_s};
   assign hit = (hdr[13:12] == ST_CODE) && (hdr[9:5] == addr_s) && !dis_s;
   assign hdr_end = mdc_rise && (state_q == MS_HDR) && (bitcnt_q == HDR_LAST);
   assign rd_clear = hdr_end && hit && (hdr[11:10] == OP_RD) && (hdr[4:0] == REG_IRQ_ST);
   assign wr_commit = mdc_rise && (state_q == MS_DATA) && (bitcnt_q == DATA_LAST) && wr_q;
   assign wr_word = {sh_q[14:0], mdio_s};
   assign ctrl_wr = wr_commit && (reg_q == REG_CTRL) && init_done && !dis_s;
   assign soft_rst = ctrl_wr && wr_word[CTRL_RESET_BIT];

   // Register read mux
   always_comb begin
      rd_word = 16'h0000;
      case (hdr[4:0])
         REG_CTRL: rd_word = ctrl_q;
         REG_STAT: rd_word[STAT_LINK_BIT] = line_link;
         REG_IRQ_EN: rd_word = irq_en_q;
         REG_IRQ_ST: rd_word = irq_st_q;
         default: rd_word = 16'h0000;
      endcase
   end

   // Serial frame receiver
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= MS_PRE;
         ones_q <= 6'h00;
         bitcnt_q <= 6'h00;
         sh_q <= 16'h0000;
         rd_q <= 1'h0;
         wr_q <= 1'h0;
         reg_q <= 5'h00;
         rdata_q <= 16'h0000;
         mdio_o_q <= 1'h0;
         mdio_oe_q <= 1'h0;
      end else if (mdc_rise) begin
         sh_q <= {sh_q[14:0], mdio_s};
         case (state_q)
            MS_PRE: begin
               if (mdio_s) begin
                  ones_q <= (ones_q == PRE_BITS) ? ones_q : ones_q + 6'h01;
               end else begin
                  ones_q <= 6'h00;
                  if (ones_q == PRE_BITS) begin
                     state_q <= MS_HDR;
                     bitcnt_q <= 6'h01;
                  end
               end
            end
            MS_HDR: begin
               bitcnt_q <= bitcnt_q + 6'h01;
               if (bitcnt_q == HDR_LAST) begin
                  state_q <= MS_DATA;
                  rd_q <= hit && (hdr[11:10] == OP_RD);
                  wr_q <= hit && (hdr[11:10] == OP_WR);
                  reg_q <= hdr[4:0];
                  rdata_q <= rd_word;
               end
            end
            MS_DATA: begin
               bitcnt_q <= bitcnt_q + 6'h01;
               if (bitcnt_q == TA_DRIVE) begin
                  mdio_oe_q <= rd_q;
                  mdio_o_q <= 1'h0;
               end else if (bitcnt_q == DATA_LAST) begin
                  mdio_oe_q <= 1'h0;
                  state_q <= MS_PRE;
                  rd_q <= 1'h0;
                  wr_q <= 1'h0;
               end else begin
                  mdio_o_q <= rdata_q[15];
                  rdata_q <= {rdata_q[14:0], 1'h0};
               end
            end
            default: begin
               state_q <= MS_PRE;
               ones_q <= 6'h00;
            end
         endcase
      end
   end
   assign mii.phy_mdio_o = mdio_o_q;
   assign mii.phy_mdio_oe = mdio_oe_q;

   // Control register and pin seeding
   assign init_done = (init_cnt_q == CFG_LOAD_CYC);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         init_cnt_q <= 2'h0;
         ctrl_q <= CTRL_RST_VAL;
      end else begin
         if (soft_rst) begin
            init_cnt_q <= 2'h0;
         end else if (!init_done) begin
            init_cnt_q <= init_cnt_q + 2'h1;
         end
         if (soft_rst) begin
            ctrl_q <= CTRL_RST_VAL;
         end else if (ctrl_wr) begin
            ctrl_q <= wr_word & ~CTRL_RESET_MASK;
         end else if (!init_done || dis_s) begin
            ctrl_q[CTRL_SPEED_BIT] <= spd_s;
            ctrl_q[CTRL_DUPLEX_BIT] <= dup_s;
         end
      end
   end
   assign speed100 = ctrl_q[CTRL_SPEED_BIT];
   assign full_duplex = ctrl_q[CTRL_DUPLEX_BIT];

   // Interrupt enable and status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_en_q <= IRQ_EN_RST_VAL;
         irq_st_q <= 16'h0000;
         link_prev_q <= 1'h0;
      end else begin
         link_prev_q <= line_link;
         if (soft_rst) begin
            irq_en_q <= IRQ_EN_RST_VAL;
         end else if (wr_commit && !dis_s && (reg_q == REG_IRQ_EN)) begin
            irq_en_q <= wr_word;
         end
         // Set wins over read clear
         irq_st_q[IRQ_ST_LINK_BIT] <= (line_link ^ link_prev_q) |
                                      (irq_st_q[IRQ_ST_LINK_BIT] & ~rd_clear);
      end
   end
   assign mii.phy_irq_oe = irq_en_q[IRQ_EN_BIT] & irq_st_q[IRQ_ST_LINK_BIT];

   // MII clock divider
   assign half = speed100 ? MII_HALF_100 : MII_HALF_10;
   assign tick = (div_q >= half - 5'h01);
   assign rise_evt = tick && !mii_clk_q;
   assign fall_evt = tick && mii_clk_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= 5'h00;
         mii_clk_q <= 1'h0;
      end else if (tick) begin
         div_q <= 5'h00;
         mii_clk_q <= ~mii_clk_q;
      end else begin
         div_q <= div_q + 5'h01;
      end
   end
   assign mii.tx_clk = mii_clk_q;
   assign mii.rx_clk = mii_clk_q;

   // Transmit capture mid-period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line_tx_data <= 4'h0;
         line_tx_en <= 1'h0;
         line_tx_er <= 1'h0;
      end else if (fall_evt) begin
         line_tx_data <= txd_s;
         line_tx_en <= tx_en_s;
         line_tx_er <= tx_er_s;
      end
   end

   // Receive launch on clock rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rxd_q <= 4'h0;
         rx_dv_q <= 1'h0;
         rx_er_q <= 1'h0;
      end else if (rise_evt) begin
         rxd_q <= line_rx_data;
         rx_dv_q <= line_rx_dv;
         rx_er_q <= line_rx_er;
      end
   end
   assign line_rx_take = rise_evt;
   assign mii.rxd = rxd_q;
   assign mii.rx_dv = rx_dv_q;
   assign mii.rx_er = rx_er_q;

   // Carrier sense and collision
   assign crs_raw = line_carrier | (!full_duplex & line_tx_en);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         crs_hold_q <= 1'h0;
      end else if (rise_evt) begin
         crs_hold_q <= crs_raw;
      end
   end
   assign mii.crs = crs_raw | crs_hold_q;
   assign mii.col = !full_duplex & line_tx_en & line_carrier;
endmodule // phm_phy
`default_nettype wire

// ### design/phm_pkg.sv
// Purpose: shared constants for the MII and management link
// Assumes: 100 MHz system clock on both ends
// Notes: register indices are management register numbers
package phm_pkg;
   // System and link rates in kHz
   localparam int CLK_KHZ = 100000;
   localparam int MII_100_KHZ = 25000;
   localparam int MII_10_KHZ = 2500;
   localparam int MDC_MAX_KHZ = 8000;
   // Half periods and config load count in system clocks
   localparam logic [4:0] MII_HALF_100 = 5'(CLK_KHZ / (2 * MII_100_KHZ));
   localparam logic [4:0] MII_HALF_10 = 5'(CLK_KHZ / (2 * MII_10_KHZ));
   localparam logic [3:0] MDC_HALF = 4'((CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ));
   localparam logic [1:0] CFG_LOAD_CYC = 2'h3;
   // Management registers
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   localparam logic [4:0] REG_IRQ_EN = 5'h12;
   localparam logic [4:0] REG_IRQ_ST = 5'h13;
   localparam int CTRL_RESET_BIT = 15;
   localparam int CTRL_SPEED_BIT = 13;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int STAT_LINK_BIT = 2;
   localparam int IRQ_EN_BIT = 1;
   localparam int IRQ_ST_LINK_BIT = 2;
   localparam logic [15:0] CTRL_RST_VAL = 16'h0000;
   localparam logic [15:0] IRQ_EN_RST_VAL = 16'h0000;
   localparam logic [15:0] CTRL_RESET_MASK = 16'(1 << CTRL_RESET_BIT);
   // Serial frame
   localparam logic [31:0] PRE_ONES = 32'hFFFF_FFFF;
   localparam logic [5:0] PRE_BITS = 6'h20;
   localparam logic [1:0] ST_CODE = 2'h1;
   localparam logic [1:0] OP_RD = 2'h2;
   localparam logic [1:0] OP_WR = 2'h1;
   localparam logic [1:0] TA_WR = 2'h2;
   localparam logic [5:0] HDR_LAST = 6'h0D;
   localparam logic [5:0] TA_DRIVE = 6'h0E;
   localparam logic [5:0] DATA_LAST = 6'h1F;
   localparam logic [5:0] RD_REL_IDX = 6'h2E;
   localparam logic [5:0] RD_CAP_IDX = 6'h30;
   localparam logic [5:0] LAST_IDX = 6'h3F;
   // Controller registers
   localparam logic [1:0] HR_CMD = 2'h0;
   localparam logic [1:0] HR_WDATA = 2'h1;
   localparam logic [1:0] HR_STAT = 2'h2;
   localparam logic [1:0] HR_RDATA = 2'h3;
   localparam int CMD_REG_LSB = 0;
   localparam int CMD_PHY_LSB = 5;
   localparam int CMD_WR_BIT = 10;
   localparam int HS_BUSY_BIT = 0;
   localparam int HS_IRQ_BIT = 1;
   localparam int HS_CRS_BIT = 2;
   localparam int HS_COL_BIT = 3;
   // Management receiver states
   typedef enum logic [1:0] {
      MS_PRE = 2'h0,
      MS_HDR = 2'h1,
      MS_DATA = 2'h3
   } phm_mstate_e;
endpackage

// ### design/phm_if.sv
// Purpose: pins between PHY end and MAC end
// Assumes: pull-up on the serial data and interrupt lines
// Notes: wire levels resolved from enables here
`timescale 1ns/1ns
`default_nettype none
interface phm_if;
   logic tx_clk;
   logic rx_clk;
   logic [3:0] txd;
   logic tx_en;
   logic tx_er;
   logic [3:0] rxd;
   logic rx_dv;
   logic rx_er;
   logic col;
   logic crs;
   logic mdc;
   logic sta_mdio_o;
   logic sta_mdio_oe;
   logic phy_mdio_o;
   logic phy_mdio_oe;
   logic mdio;
   logic phy_irq_oe;
   logic status_change_irq_n;
   // Pulled-up shared lines
   assign mdio = (~sta_mdio_oe | sta_mdio_o) & (~phy_mdio_oe | phy_mdio_o);
   assign status_change_irq_n = ~phy_irq_oe;
   modport phy (
      output tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs,
      output phy_mdio_o, phy_mdio_oe, phy_irq_oe,
      input txd, tx_en, tx_er, mdc, mdio
   );
   modport mac (
      output txd, tx_en, tx_er, mdc, sta_mdio_o, sta_mdio_oe,
      input tx_clk, rx_clk, rxd, rx_dv, rx_er, col, crs, mdio,
      input status_change_irq_n
   );
endinterface
`default_nettype wire

// ### design/phm_sync.sv
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: each bit is a level, not a pulse
// Notes: first stage read only by the second
`timescale 1ns/1ns
`default_nettype none
module phm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // phm_sync
`default_nettype wire

// ### design/phm_mac.sv
// Purpose: MAC and station manager end of the link
// Assumes: PHY clocks and pins cross two flops
// Notes: one management frame at a time
`timescale 1ns/1ns
`default_nettype none
module phm_mac
   import phm_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // MII and management pins
   phm_if.mac mii,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Transmit stream
   input wire logic [3:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_err,
   output logic tx_take,
   // Receive stream
   output logic [3:0] rx_data,
   output logic rx_valid,
   output logic rx_err,
   output logic rx_strobe
);
   logic [11:0] pin_s;
   logic txclk_s;
   logic rxclk_s;
   logic [3:0] rxd_s;
   logic rx_dv_s;
   logic rx_er_s;
   logic crs_s;
   logic col_s;
   logic mdio_s;
   logic irq_s;
   logic txclk_prev_q;
   logic rxclk_prev_q;
   logic tx_rise;
   logic rx_rise;
   logic [3:0] txd_q;
   logic tx_en_q;
   logic tx_er_q;
   logic [15:0] cmd_q;
   logic [15:0] wdata_q;
   logic [15:0] rdata_q;
   logic [15:0] rd_sh_q;
   logic busy_q;
   logic [3:0] mcnt_q;
   logic mdc_q;
   logic [5:0] idx_q;
   logic [63:0] frame_q;
   logic sta_o_q;
   logic sta_oe_q;
   logic start;
   logic [15:0] stat;

   phm_sync #(.W(12)) u_sync (
      .clk(clk),
      .resetn(resetn),
      .d({mii.tx_clk, mii.rx_clk, mii.rxd, mii.rx_dv, mii.rx_er, mii.crs, mii.col,
          mii.mdio, ~mii.status_change_irq_n}),
      .q(pin_s)
   );
   assign {txclk_s, rxclk_s, rxd_s, rx_dv_s, rx_er_s, crs_s, col_s, mdio_s, irq_s} = pin_s;

   // MII clock edges
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txclk_prev_q <= 1'h0;
         rxclk_prev_q <= 1'h0;
      end else begin
         txclk_prev_q <= txclk_s;
         rxclk_prev_q <= rxclk_s;
      end
   end
   assign tx_rise = txclk_s & ~txclk_prev_q;
   assign rx_rise = rxclk_s & ~rxclk_prev_q;

   // Transmit launch after clock rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txd_q <= 4'h0;
         tx_en_q <= 1'h0;
         tx_er_q <= 1'h0;
      end else if (tx_rise) begin
         txd_q <= tx_valid ? tx_data : 4'h0;
         tx_en_q <= tx_valid;
         tx_er_q <= tx_valid & tx_err;
      end
   end
   assign tx_take = tx_rise & tx_valid;
   assign mii.txd = txd_q;
   assign mii.tx_en = tx_en_q;
   assign mii.tx_er = tx_er_q;

   // Receive capture
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_data <= 4'h0;
         rx_valid <= 1'h0;
         rx_err <= 1'h0;
         rx_strobe <= 1'h0;
      end else begin
         rx_strobe <= rx_rise;
         if (rx_rise) begin
            rx_data <= rxd_s;
            rx_valid <= rx_dv_s;
            rx_err <= rx_er_s;
         end
      end
   end

   // Register writes
   assign start = reg_wr && (reg_addr == HR_CMD) && !busy_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd_q <= 16'h0000;
         wdata_q <= 16'h0000;
      end else if (reg_wr) begin
         if (start) begin
            cmd_q <= reg_wdata;
         end
         if (reg_addr == HR_WDATA) begin
            wdata_q <= reg_wdata;
         end
      end
   end

   // Management frame engine
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'h0;
         mcnt_q <= 4'h0;
         mdc_q <= 1'h0;
         idx_q <= 6'h00;
         frame_q <= 64'h0;
         sta_o_q <= 1'h0;
         sta_oe_q <= 1'h0;
         rd_sh_q <= 16'h0000;
         rdata_q <= 16'h0000;
      end else if (start) begin
         busy_q <= 1'h1;
         mcnt_q <= 4'h0;
         mdc_q <= 1'h0;
         idx_q <= 6'h00;
         frame_q <= {PRE_ONES, ST_CODE, reg_wdata[CMD_WR_BIT] ? OP_WR : OP_RD,
                     reg_wdata[CMD_PHY_LSB +: 5], reg_wdata[CMD_REG_LSB +: 5],
                     TA_WR, wdata_q};
         sta_o_q <= 1'h1;
         sta_oe_q <= 1'h1;
      end else if (busy_q) begin
         if (mcnt_q == MDC_HALF - 4'h1) begin
            mcnt_q <= 4'h0;
            mdc_q <= ~mdc_q;
            if (!mdc_q) begin
               if (idx_q >= RD_CAP_IDX) begin
                  rd_sh_q <= {rd_sh_q[14:0], mdio_s};
               end
               if ((idx_q == LAST_IDX) && !cmd_q[CMD_WR_BIT]) begin
                  rdata_q <= {rd_sh_q[14:0], mdio_s};
               end
            end else if (idx_q == LAST_IDX) begin
               // Frame ends on the fall, clock idles low
               busy_q <= 1'h0;
               sta_oe_q <= 1'h0;
            end else begin
               idx_q <= idx_q + 6'h01;
               frame_q <= {frame_q[62:0], 1'h0};
               sta_o_q <= frame_q[62];
               sta_oe_q <= cmd_q[CMD_WR_BIT] || ((idx_q + 6'h01) < RD_REL_IDX);
            end
         end else begin
            mcnt_q <= mcnt_q + 4'h1;
         end
      end
   end
   assign mii.mdc = mdc_q;
   assign mii.sta_mdio_o = sta_o_q;
   assign mii.sta_mdio_oe = sta_oe_q;

   // Status word; software reads PHY register 19 to release
   always_comb begin
      stat = 16'h0000;
      stat[HS_BUSY_BIT] = busy_q;
      stat[HS_IRQ_BIT] = irq_s;
      stat[HS_CRS_BIT] = crs_s;
      stat[HS_COL_BIT] = col_s;
   end

   // Register reads, data one cycle later
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            HR_CMD: reg_rdata <= cmd_q;
            HR_WDATA: reg_rdata <= wdata_q;
            HR_STAT: reg_rdata <= stat;
            HR_RDATA: reg_rdata <= rdata_q;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule // phm_mac
`default_nettype wire

// ### testbench/phm_link_sva.sv
// Purpose: link checker for the phm ends
// Assumes: 100 MHz clk, link signals sampled as levels
// Notes: watches interface signals only
`timescale 1ns/1ns
`default_nettype none
module phm_link_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link
   input wire logic tx_clk,
   input wire logic rx_clk,
   input wire logic [3:0] txd,
   input wire logic tx_en,
   input wire logic tx_er,
   input wire logic [3:0] rxd,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic col,
   input wire logic crs,
   input wire logic mdc,
   input wire logic sta_mdio_oe,
   input wire logic phy_mdio_oe,
   input wire logic status_change_irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_launch;
      $past(tx_clk, 3) && !$past(tx_clk, 4);
   endsequence
   sequence s_high_half;
      tx_clk ##[1:19] $fell(tx_clk);
   endsequence
   property p_tx_sync;
      $changed({txd, tx_en, tx_er}) |-> s_launch;
   endproperty
   a_tx_sync: assert property (p_tx_sync) else $error("tx moved off launch");
   property p_tx_half;
      $rose(tx_clk) |=> s_high_half;
   endproperty
   a_tx_half: assert property (p_tx_half) else $error("tx clock half bad");
   property p_rx_sync;
      $changed({rxd, rx_dv, rx_er}) |-> $rose(rx_clk);
   endproperty
   a_rx_sync: assert property (p_rx_sync) else $error("rx moved off edge");
   property p_crs_fall;
      $fell(crs) |-> $rose(rx_clk);
   endproperty
   a_crs_fall: assert property (p_crs_fall) else $error("carrier fell off edge");
   property p_col_crs;
      col |-> crs;
   endproperty
   a_col_crs: assert property (p_col_crs) else $error("collision w/o carrier");
   property p_mdc_high;
      $rose(mdc) |-> mdc [*7] ##1 !mdc;
   endproperty
   a_mdc_high: assert property (p_mdc_high) else $error("mgmt clock high bad");
   property p_mdio_one;
      !(sta_mdio_oe && phy_mdio_oe);
   endproperty
   a_mdio_one: assert property (p_mdio_one) else $error("mgmt data contention");
   property p_irq_rel;
      $rose(status_change_irq_n) |-> sta_mdio_oe;
   endproperty
   a_irq_rel: assert property (p_irq_rel) else $error("irq freed off frame");
endmodule // phm_link_sva
`default_nettype wire

// ### testbench/phy_mii_mgmt_interface_bench.sv
// Purpose: bench for both ends of the phm link
// Assumes: 100 MHz clk, seed 8828
// Notes: frames polled through the busy bit
`timescale 1ns/1ns
`default_nettype none
module phy_mii_mgmt_interface_bench;
   import phm_pkg::*;
   localparam logic [4:0] PA = 5'h05;
   logic clk = 1'b0, resetn = 1'b0, dis = 1'b0, spd = 1'b1, fdx = 1'b0, link = 1'b0;
   logic carr = 1'b0, rdv = 1'b0, rer = 1'b0, wr_s = 1'b0, rd_s = 1'b0, tv = 1'b0, te = 1'b0;
   logic [3:0] rdat = 4'h0, tdat = 4'h0, ltd, rxo;
   logic [1:0] ra = 2'h0;
   logic [15:0] wd = 16'h0000, rq, q;
   logic ltx_en, ltx_er, s100, fd, rv, re;
   int seed = 8828, fail_count = 0, checks_done = 0, cyc = 0;
   phm_if mii ();
   phm_phy i_phm_phy (.clk(clk), .resetn(resetn), .mii(mii.phy), .mgmt_disable_pin(dis),
      .phy_addr_pin(PA), .cfg_speed100_pin(spd), .cfg_full_duplex_pin(fdx),
      .line_tx_data(ltd), .line_tx_en(ltx_en), .line_tx_er(ltx_er), .line_rx_data(rdat),
      .line_rx_dv(rdv), .line_rx_er(rer), .line_rx_take(), .line_carrier(carr),
      .line_link(link), .speed100(s100), .full_duplex(fd));
   phm_mac i_phm_mac (.clk(clk), .resetn(resetn), .mii(mii.mac), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rq), .tx_data(tdat),
      .tx_valid(tv), .tx_err(te), .tx_take(), .rx_data(rxo), .rx_valid(rv), .rx_err(re),
      .rx_strobe());
   phm_link_sva i_phm_link_sva (.clk(clk), .resetn(resetn), .tx_clk(mii.tx_clk),
      .rx_clk(mii.rx_clk), .txd(mii.txd), .tx_en(mii.tx_en), .tx_er(mii.tx_er),
      .rxd(mii.rxd), .rx_dv(mii.rx_dv), .rx_er(mii.rx_er), .col(mii.col), .crs(mii.crs),
      .mdc(mii.mdc), .sta_mdio_oe(mii.sta_mdio_oe), .phy_mdio_oe(mii.phy_mdio_oe),
      .status_change_irq_n(mii.status_change_irq_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      ra <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      ra <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      d = rq;
   endtask
   // One management frame, waits for busy to drop
   task automatic mgmt(input logic w, input logic [4:0] pa, input logic [4:0] r,
         input logic [15:0] d, output logic [15:0] o);
      logic [15:0] s;
      int n;
      wr(HR_WDATA, d);
      wr(HR_CMD, 16'({w, pa, r}));
      s = 16'h0001;
      n = 0;
      while (s[HS_BUSY_BIT] !== 1'b0 && n < 1000) begin
         rd(HR_STAT, s);
         n++;
      end
      chk(16'(s[HS_BUSY_BIT]), 16'h0000);
      rd(HR_RDATA, o);
   endtask
   // Expected collision and carrier for one nibble
   function automatic logic [1:0] exp_cc(input logic hd, input logic c);
      return {hd & c, hd | c};
   endfunction
   // Nibbles both ways with carrier and collision
   task automatic dp(input logic hd);
      logic [10:0] v;
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 11'h7FF : 11'($random(seed));
         @(posedge clk);
         tdat <= v[3:0];
         te <= v[4];
         tv <= 1'b1;
         rdat <= v[8:5];
         rdv <= 1'b1;
         rer <= v[9];
         carr <= v[10];
         repeat (100) @(posedge clk);
         chk({ltd, ltx_en, ltx_er}, {v[3:0], 1'b1, v[4]});
         chk({rxo, rv, re}, {v[8:5], 1'b1, v[9]});
         chk({mii.col, mii.crs}, exp_cc(hd, v[10]));
      end
      tv <= 1'b0;
      rdv <= 1'b0;
      carr <= 1'b0;
      repeat (100) @(posedge clk);
      chk({ltx_en, rv, mii.crs, mii.col}, 4'h0);
   endtask
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (10) @(posedge clk);
      chk({s100, fd}, 2'b10);
      spd <= 1'b0;
      fdx <= 1'b1;
      dp(1'b1);
      chk({s100, fd}, 2'b10);
      mgmt(1'b1, PA, REG_CTRL, 16'h0100, q);
      mgmt(1'b0, PA, REG_CTRL, 16'h0000, q);
      chk(q, 16'h0100);
      chk({s100, fd}, 2'b01);
      mgmt(1'b0, PA ^ 5'h01, REG_CTRL, 16'h0000, q);
      chk(q, 16'hFFFF);
      dp(1'b0);
      mgmt(1'b1, PA, REG_IRQ_EN, 16'h0002, q);
      @(posedge clk);
      link <= 1'b1;
      repeat (10) @(posedge clk);
      chk(mii.status_change_irq_n, 1'b0);
      rd(HR_STAT, q);
      chk(16'(q[HS_IRQ_BIT]), 16'h0001);
      mgmt(1'b0, PA, REG_IRQ_ST, 16'h0000, q);
      chk(q, 16'h0004);
      chk(mii.status_change_irq_n, 1'b1);
      @(posedge clk);
      dis <= 1'b1;
      spd <= 1'b1;
      fdx <= 1'b0;
      mgmt(1'b1, PA, REG_IRQ_EN, 16'h0000, q);
      mgmt(1'b0, PA, REG_IRQ_EN, 16'h0000, q);
      chk(q, 16'hFFFF);
      chk({s100, fd}, 2'b10);
      @(posedge clk);
      dis <= 1'b0;
      mgmt(1'b0, PA, REG_IRQ_EN, 16'h0000, q);
      chk(q, 16'h0002);
      finish_test();
   end
endmodule // phy_mii_mgmt_interface_bench
`default_nettype wire
